//--- iox_map.svh
// register selections, bus offsets and timing constants of the expander
`ifndef IOX_MAP_SVH
`define IOX_MAP_SVH

`define IOX_ADDR_HI   4'h4
`define IOX_SEL_IN0   3'h0
`define IOX_SEL_IN1   3'h1
`define IOX_SEL_OUT0  3'h2
`define IOX_SEL_OUT1  3'h3
`define IOX_SEL_INV0  3'h4
`define IOX_SEL_INV1  3'h5
`define IOX_SEL_DIR0  3'h6
`define IOX_SEL_DIR1  3'h7
`define IOX_PAIR_BIT  3'h1
`define IOX_OUT_RST   8'hFF
`define IOX_INV_RST   8'h00
`define IOX_DIR_RST   8'hFF
`define IOX_BITS      4'h8
`define IOX_LAST_TX   4'h7

`define IOX_WB_CTRL   3'h0
`define IOX_WB_ADDR   3'h1
`define IOX_WB_CMD    3'h2
`define IOX_WB_WDATA  3'h3
`define IOX_WB_RDATA  3'h4
`define IOX_WB_STAT   3'h5
`define IOX_CB_GO     0
`define IOX_CB_RD     1
`define IOX_CB_TWO    2

`define IOX_B_ADDRW   3'h0
`define IOX_B_CMD     3'h1
`define IOX_B_WDAT0   3'h2
`define IOX_B_ADDRR   3'h2
`define IOX_B_RDAT0   3'h3
`define IOX_BIT_ACK   4'h8

`define IOX_SCL_QTR_NS 625
`define IOX_CLK_NS     40

`endif

//--- iox_pkg.sv
// shared types of the expander target and its bus controller
package iox_pkg;
   typedef logic [2:0] iox_sel_t;
   typedef enum logic [3:0]
   {
      T_IDLE = 4'h0,
      T_ADDR = 4'h1,
      T_AACK = 4'h3,
      T_CMD  = 4'h2,
      T_CACK = 4'h6,
      T_WDAT = 4'h7,
      T_WACK = 4'h5,
      T_RDAT = 4'h4,
      T_RACK = 4'hC
   } iox_tstate_t;
   typedef enum logic [1:0]
   {
      C_IDLE  = 2'h0,
      C_START = 2'h1,
      C_BYTE  = 2'h3,
      C_STOP  = 2'h2
   } iox_cstate_t;
endpackage : iox_pkg

//--- iox_i2c_if.sv
// two-wire bus between controller and expander, open-drain resolved
`timescale 1ns/1ps
interface iox_i2c_if;
   logic ctrlSclOut;
   logic ctrlSclOe;
   logic ctrlSdaOut;
   logic ctrlSdaOe;
   logic tgtSdaOut;
   logic tgtSdaOe;
   logic scl;
   logic sda;

   // pull-up wins unless some enabled driver pulls low
   assign scl = ~(ctrlSclOe & ~ctrlSclOut);
   assign sda = ~((ctrlSdaOe & ~ctrlSdaOut) | (tgtSdaOe & ~tgtSdaOut));

   modport ctrl (output ctrlSclOut, ctrlSclOe, ctrlSdaOut, ctrlSdaOe, input scl, sda);
   modport tgt  (output tgtSdaOut, tgtSdaOe, input scl, sda);
endinterface : iox_i2c_if

//--- iox_target.sv
// expander end: two-wire target with eight byte registers and pin logic
`timescale 1ns/1ps
`include "iox_map.svh"
module iox_target
   import iox_pkg::*;
(
   iox_i2c_if.tgt      bus,
   input  logic        sys_clk,
   input  logic        resetn,
   input  logic [2:0]  addrStrap,
   input  logic [15:0] pinIn,
   output logic [15:0] pinOut,
   output logic [15:0] pinOe
);

   logic [2:0]  sclSy_r;
   logic [2:0]  sdaSy_r;
   logic        sclF_r;
   logic        sdaF_r;
   logic        sclQ_r;
   logic        sdaQ_r;
   logic [15:0] pinA_r;
   logic [15:0] pinB_r;
   logic [15:0] pinC_r;
   logic [15:0] pinF_r;
   logic [2:0]  strap_r;
   iox_tstate_t state_r;
   logic [3:0]  bitCnt_r;
   logic [7:0]  rxSh_r;
   logic [7:0]  txSh_r;
   logic        sdaLow_r;
   logic        rdMode_r;
   logic        ackd_r;
   iox_sel_t    cmdSel_r;
   iox_sel_t    accSel_r;
   logic [7:0]  regs_r [`IOX_SEL_OUT0:`IOX_SEL_DIR1];
   logic        sclRise;
   logic        sclFall;
   logic        startC;
   logic        stopC;
   logic        wrHit;
   logic [15:0] inLvl;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic agree(input logic f, input logic b, input logic c);
      // keep the old level until the two late stages match
      return (b & c) | (f & (b ^ c));
   endfunction : agree

   function automatic iox_sel_t pairMate(input iox_sel_t s);
      return s ^ `IOX_PAIR_BIT;
   endfunction : pairMate

   function automatic logic [7:0] rstVal(input iox_sel_t s);
      case (s)
         `IOX_SEL_INV0, `IOX_SEL_INV1: return `IOX_INV_RST;
         `IOX_SEL_DIR0, `IOX_SEL_DIR1: return `IOX_DIR_RST;
         default:                      return `IOX_OUT_RST;
      endcase
   endfunction : rstVal

   function automatic logic [7:0] selData(input iox_sel_t s);
      case (s)
         `IOX_SEL_IN0: return inLvl[7:0];
         `IOX_SEL_IN1: return inLvl[15:8];
         default:      return regs_r[s];
      endcase
   endfunction : selData

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         sclSy_r <= 3'h7;
         sdaSy_r <= 3'h7;
         sclF_r  <= 1'b1;
         sdaF_r  <= 1'b1;
         sclQ_r  <= 1'b1;
         sdaQ_r  <= 1'b1;
      end
      else
      begin
         sclSy_r <= {sclSy_r[1:0], bus.scl};
         sdaSy_r <= {sdaSy_r[1:0], bus.sda};
         sclF_r  <= agree(sclF_r, sclSy_r[1], sclSy_r[2]);
         sdaF_r  <= agree(sdaF_r, sdaSy_r[1], sdaSy_r[2]);
         sclQ_r  <= sclF_r;
         sdaQ_r  <= sdaF_r;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         pinA_r <= 16'h0000;
         pinB_r <= 16'h0000;
         pinC_r <= 16'h0000;
         pinF_r <= 16'h0000;
      end
      else
      begin
         pinA_r <= pinIn;
         pinB_r <= pinA_r;
         pinC_r <= pinB_r;
         pinF_r <= (pinB_r & pinC_r) | (pinF_r & (pinB_r ^ pinC_r));
      end
   end

   // straps must stay put while powered, so catch them during reset
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         strap_r <= addrStrap;
   end

   assign sclRise = sclF_r & ~sclQ_r;
   assign sclFall = ~sclF_r & sclQ_r;
   assign startC  = sclF_r & sclQ_r & sdaQ_r & ~sdaF_r;
   assign stopC   = sclF_r & sclQ_r & ~sdaQ_r & sdaF_r;
   // invert reported level where the mask bit is set
   assign inLvl   = pinF_r ^ {regs_r[`IOX_SEL_INV1], regs_r[`IOX_SEL_INV0]};
   // store at ACK rise, never into the input pair
   assign wrHit   = (state_r == T_WACK) && sclRise && (accSel_r >= `IOX_SEL_OUT0);

   assign bus.tgtSdaOut = 1'b0;
   assign bus.tgtSdaOe  = sdaLow_r;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         for (int i = `IOX_SEL_OUT0; i <= `IOX_SEL_DIR1; i++)
            regs_r[i] <= rstVal(iox_sel_t'(i));
      end
      else if (wrHit)
         regs_r[accSel_r] <= rxSh_r;
   end

   // direction bit one releases the driver
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         pinOut <= {`IOX_OUT_RST, `IOX_OUT_RST};
         pinOe  <= ~{`IOX_DIR_RST, `IOX_DIR_RST};
      end
      else
      begin
         pinOut <= {regs_r[`IOX_SEL_OUT1], regs_r[`IOX_SEL_OUT0]};
         pinOe  <= ~{regs_r[`IOX_SEL_DIR1], regs_r[`IOX_SEL_DIR0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         state_r  <= T_IDLE;
         bitCnt_r <= 4'h0;
         rxSh_r   <= 8'h00;
         txSh_r   <= 8'h00;
         sdaLow_r <= 1'b0;
         rdMode_r <= 1'b0;
         ackd_r   <= 1'b0;
         cmdSel_r <= `IOX_SEL_IN0;
         accSel_r <= `IOX_SEL_IN0;
      end
      // stop ends any phase, stored data stays
      else if (stopC)
      begin
         state_r  <= T_IDLE;
         sdaLow_r <= 1'b0;
      end
      else if (startC)
      begin
         state_r  <= T_ADDR;
         bitCnt_r <= 4'h0;
         sdaLow_r <= 1'b0;
         // repeated start keeps the register in flight
         if (state_r != T_IDLE)
            cmdSel_r <= accSel_r;
         else
            accSel_r <= cmdSel_r;
      end
      else
      begin
         case (state_r)
            T_ADDR, T_CMD, T_WDAT:
            begin
               if (sclRise)
               begin
                  rxSh_r   <= {rxSh_r[6:0], sdaF_r};
                  bitCnt_r <= bitCnt_r + 4'h1;
               end
               else if (sclFall && bitCnt_r == `IOX_BITS)
               begin
                  sdaLow_r <= 1'b1;
                  case (state_r)
                     T_CMD:  state_r <= T_CACK;
                     T_WDAT: state_r <= T_WACK;
                     default:
                     begin
                        // fixed part plus straps or stay silent
                        if (rxSh_r[7:1] == {`IOX_ADDR_HI, strap_r})
                        begin
                           rdMode_r <= rxSh_r[0];
                           state_r  <= T_AACK;
                        end
                        else
                        begin
                           sdaLow_r <= 1'b0;
                           state_r  <= T_IDLE;
                        end
                     end
                  endcase
               end
            end
            T_AACK:
            begin
               // register data captured at the ACK rise
               if (sclRise && rdMode_r)
                  txSh_r <= selData(accSel_r);
               else if (sclFall)
               begin
                  bitCnt_r <= 4'h0;
                  // read phases carry no selection byte
                  state_r  <= rdMode_r ? T_RDAT : T_CMD;
                  sdaLow_r <= rdMode_r & ~txSh_r[7];
               end
            end
            T_CACK:
            begin
               // selection held until the next one
               if (sclRise)
               begin
                  cmdSel_r <= rxSh_r[2:0];
                  accSel_r <= rxSh_r[2:0];
               end
               else if (sclFall)
               begin
                  sdaLow_r <= 1'b0;
                  bitCnt_r <= 4'h0;
                  state_r  <= T_WDAT;
               end
            end
            T_WACK:
            begin
               if (sclFall)
               begin
                  accSel_r <= pairMate(accSel_r);
                  sdaLow_r <= 1'b0;
                  bitCnt_r <= 4'h0;
                  state_r  <= T_WDAT;
               end
            end
            T_RDAT:
            begin
               if (sclFall)
               begin
                  if (bitCnt_r == `IOX_LAST_TX)
                  begin
                     sdaLow_r <= 1'b0;
                     state_r  <= T_RACK;
                  end
                  else
                  begin
                     bitCnt_r <= bitCnt_r + 4'h1;
                     txSh_r   <= {txSh_r[6:0], 1'b0};
                     sdaLow_r <= ~txSh_r[6];
                  end
               end
            end
            T_RACK:
            begin
               if (sclRise)
               begin
                  ackd_r <= ~sdaF_r;
                  // each acked byte fetches the pair mate
                  if (!sdaF_r)
                  begin
                     accSel_r <= pairMate(accSel_r);
                     txSh_r   <= selData(pairMate(accSel_r));
                  end
               end
               else if (sclFall)
               begin
                  bitCnt_r <= 4'h0;
                  state_r  <= ackd_r ? T_RDAT : T_IDLE;
                  sdaLow_r <= ackd_r & ~txSh_r[7];
               end
            end
            default: state_r <= T_IDLE;
         endcase
      end
   end

endmodule : iox_target

//--- iox_ctrl.sv
// controller end: Wishbone-programmed two-wire master for the expander
`timescale 1ns/1ps
`include "iox_map.svh"
module iox_ctrl
   import iox_pkg::*;
#(
   parameter int QTR_CYC = (`IOX_SCL_QTR_NS + `IOX_CLK_NS - 1) / `IOX_CLK_NS
)
(
   iox_i2c_if.ctrl     bus,
   input  logic        sys_clk,
   input  logic        resetn,
   input  logic        wb_cyc_i,
   input  logic        wb_stb_i,
   input  logic        wb_we_i,
   input  logic [7:0]  wb_adr_i,
   input  logic [3:0]  wb_sel_i,
   input  logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic        wb_ack_o
);

   logic [6:0]  tAddr_r;
   logic [7:0]  cmd_r;
   logic [15:0] wData_r;
   logic [15:0] rData_r;
   logic        rdFlag_r;
   logic        twoFlag_r;
   logic        busy_r;
   logic        nack_r;
   iox_cstate_t state_r;
   logic [1:0]  phase_r;
   logic [3:0]  bitNo_r;
   logic [2:0]  byteNo_r;
   logic [7:0]  txSh_r;
   logic [7:0]  rxSh_r;
   logic        ackBit_r;
   logic [7:0]  qCnt_r;
   logic        sclLow_r;
   logic        sdaLow_r;
   logic [2:0]  sdaSy_r;
   logic        sdaF_r;
   logic        wbReq;
   logic        wbWr;
   logic [2:0]  wbIdx;
   logic        go;
   logic        tick;
   logic        isRx;
   logic        isLast;
   logic [2:0]  lastNo;

   function automatic logic [7:0] txByte(input logic [2:0] n);
      case (n)
         `IOX_B_ADDRW: return {tAddr_r, 1'b0};
         `IOX_B_CMD:   return cmd_r;
         `IOX_B_WDAT0: return rdFlag_r ? {tAddr_r, 1'b1} : wData_r[7:0];
         default:      return wData_r[15:8];
      endcase
   endfunction : txByte

   assign wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wbWr   = wbReq & wb_we_i;
   assign wbIdx  = wb_adr_i[4:2];
   // a start while busy is dropped
   assign go     = wbWr && wbIdx == `IOX_WB_CTRL && wb_sel_i[0] && wb_dat_i[`IOX_CB_GO] && !busy_r;
   assign tick   = qCnt_r == 8'(QTR_CYC - 1);
   assign isRx   = rdFlag_r && byteNo_r >= `IOX_B_RDAT0;
   assign lastNo = (rdFlag_r ? `IOX_B_RDAT0 : `IOX_B_WDAT0) + {2'h0, twoFlag_r};
   assign isLast = byteNo_r == lastNo;

   assign bus.ctrlSclOut = 1'b0;
   assign bus.ctrlSclOe  = sclLow_r;
   assign bus.ctrlSdaOut = 1'b0;
   assign bus.ctrlSdaOe  = sdaLow_r;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         wb_ack_o  <= 1'b0;
         wb_dat_o  <= 32'h00000000;
         tAddr_r   <= {`IOX_ADDR_HI, 3'h0};
         cmd_r     <= 8'h00;
         wData_r   <= 16'h0000;
         rdFlag_r  <= 1'b0;
         twoFlag_r <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wbReq;
         if (wbReq)
         begin
            case (wbIdx)
               `IOX_WB_CTRL:  wb_dat_o <= {29'h0, twoFlag_r, rdFlag_r, 1'b0};
               `IOX_WB_ADDR:  wb_dat_o <= {25'h0, tAddr_r};
               `IOX_WB_CMD:   wb_dat_o <= {24'h0, cmd_r};
               `IOX_WB_WDATA: wb_dat_o <= {16'h0, wData_r};
               `IOX_WB_RDATA: wb_dat_o <= {16'h0, rData_r};
               `IOX_WB_STAT:  wb_dat_o <= {30'h0, nack_r, busy_r};
               default:       wb_dat_o <= 32'h00000000;
            endcase
         end
         // settings frozen while a transfer runs
         if (wbWr && !busy_r && wb_sel_i[0])
         begin
            case (wbIdx)
               `IOX_WB_CTRL:
               begin
                  rdFlag_r  <= wb_dat_i[`IOX_CB_RD];
                  twoFlag_r <= wb_dat_i[`IOX_CB_TWO];
               end
               `IOX_WB_ADDR:  tAddr_r <= wb_dat_i[6:0];
               `IOX_WB_CMD:   cmd_r <= wb_dat_i[7:0];
               `IOX_WB_WDATA: wData_r[7:0] <= wb_dat_i[7:0];
               default:       ;
            endcase
         end
         if (wbWr && !busy_r && wb_sel_i[1] && wbIdx == `IOX_WB_WDATA)
            wData_r[15:8] <= wb_dat_i[15:8];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         sdaSy_r <= 3'h7;
         sdaF_r  <= 1'b1;
      end
      else
      begin
         sdaSy_r <= {sdaSy_r[1:0], bus.sda};
         sdaF_r  <= (sdaSy_r[1] & sdaSy_r[2]) | (sdaF_r & (sdaSy_r[1] ^ sdaSy_r[2]));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // each bit is four quarter periods: set data, raise, sample, drop
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         state_r  <= C_IDLE;
         phase_r  <= 2'h0;
         bitNo_r  <= 4'h0;
         byteNo_r <= 3'h0;
         txSh_r   <= 8'h00;
         rxSh_r   <= 8'h00;
         ackBit_r <= 1'b1;
         qCnt_r   <= 8'h00;
         sclLow_r <= 1'b0;
         sdaLow_r <= 1'b0;
         busy_r   <= 1'b0;
         nack_r   <= 1'b0;
         rData_r  <= 16'h0000;
      end
      else
      begin
         qCnt_r <= (state_r == C_IDLE || tick) ? 8'h00 : qCnt_r + 8'h01;
         if (state_r != C_IDLE && tick)
            phase_r <= phase_r + 2'h1;
         case (state_r)
            C_IDLE:
            begin
               phase_r <= 2'h0;
               if (go)
               begin
                  busy_r   <= 1'b1;
                  nack_r   <= 1'b0;
                  byteNo_r <= `IOX_B_ADDRW;
                  state_r  <= C_START;
               end
            end
            // start and repeated start share one sequence
            C_START:
            begin
               if (tick)
               begin
                  case (phase_r)
                     2'h0: sdaLow_r <= 1'b0;
                     2'h1: sclLow_r <= 1'b0;
                     2'h2: sdaLow_r <= 1'b1;
                     default:
                     begin
                        sclLow_r <= 1'b1;
                        bitNo_r  <= 4'h0;
                        txSh_r   <= txByte(byteNo_r);
                        state_r  <= C_BYTE;
                     end
                  endcase
               end
            end
            C_BYTE:
            begin
               if (tick)
               begin
                  case (phase_r)
                     // release for read data, ack all but the last
                     2'h0: sdaLow_r <= (bitNo_r == `IOX_BIT_ACK) ? (isRx & ~isLast) : (~isRx & ~txSh_r[7]);
                     2'h1: sclLow_r <= 1'b0;
                     2'h2:
                     begin
                        if (bitNo_r == `IOX_BIT_ACK)
                           ackBit_r <= sdaF_r;
                        else
                           rxSh_r <= {rxSh_r[6:0], sdaF_r};
                     end
                     default:
                     begin
                        sclLow_r <= 1'b1;
                        if (bitNo_r != `IOX_BIT_ACK)
                        begin
                           bitNo_r <= bitNo_r + 4'h1;
                           txSh_r  <= {txSh_r[6:0], 1'b0};
                        end
                        else
                        begin
                           if (isRx && byteNo_r == `IOX_B_RDAT0)
                              rData_r[7:0] <= rxSh_r;
                           else if (isRx)
                              rData_r[15:8] <= rxSh_r;
                           if (!isRx && ackBit_r)
                           begin
                              nack_r  <= 1'b1;
                              state_r <= C_STOP;
                           end
                           else if (isLast)
                              state_r <= C_STOP;
                           else
                           begin
                              byteNo_r <= byteNo_r + 3'h1;
                              bitNo_r  <= 4'h0;
                              txSh_r   <= txByte(byteNo_r + 3'h1);
                              // repeated start before the read address
                              if (rdFlag_r && byteNo_r == `IOX_B_CMD)
                                 state_r <= C_START;
                           end
                        end
                     end
                  endcase
               end
            end
            C_STOP:
            begin
               if (tick)
               begin
                  case (phase_r)
                     2'h0: sdaLow_r <= 1'b1;
                     2'h1: sclLow_r <= 1'b0;
                     2'h2: sdaLow_r <= 1'b0;
                     default:
                     begin
                        busy_r  <= 1'b0;
                        state_r <= C_IDLE;
                     end
                  endcase
               end
            end
            default: state_r <= C_IDLE;
         endcase
      end
   end

endmodule : iox_ctrl

//--- iox_link_props.sv
// wire-level checks of the link between controller and expander
`timescale 1ns/1ps
module iox_link_props
(
   input wire logic       sys_clk,
   input wire logic       resetn,
   input wire logic       ctrlSclOe,
   input wire logic       ctrlSdaOe,
   input wire logic       tgtSdaOe,
   input wire logic       scl,
   input wire logic       sda,
   input wire logic [2:0] addrStrap
);
   logic       sclD_r, sdaD_r, first_r, act_r, rd_r, wr_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   wire        rise = scl & ~sclD_r;
   wire        sta  = scl & sclD_r & sdaD_r & ~sda;
   wire        sto  = scl & sclD_r & ~sdaD_r & sda;
   wire        ack9 = rise & act_r & (bit_r == 4'h8);
   ////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
   begin
      sclD_r <= scl;
      sdaD_r <= sda;
   end
   // ninth rise after a start is the ack slot
   always_ff @(posedge sys_clk)
   begin
      if (!resetn || sto)
      begin
         {act_r, rd_r, wr_r, first_r} <= 4'h0;
         bit_r <= 4'h0;
      end
      else if (sta)
      begin
         {act_r, rd_r, wr_r, first_r} <= 4'h9;
         bit_r <= 4'h0;
      end
      else if (ack9)
      begin
         bit_r   <= 4'h0;
         first_r <= 1'b0;
         rd_r    <= first_r ? sh_r[0] & ~sda : rd_r & ~sda;
         wr_r    <= first_r ? ~sh_r[0] & ~sda : wr_r;
      end
      else if (rise & act_r)
      begin
         bit_r <= bit_r + 4'h1;
         sh_r  <= {sh_r[6:0], sda};
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence sclHeldHigh;
      scl [*6];
   endsequence
   sequence sclHeldLow;
      !scl [*6];
   endsequence
   AST_SCL_HIGH_WIDTH:
      assert property ($rose(scl) |-> sclHeldHigh) else $error("scl high phase too short");
   AST_SCL_LOW_WIDTH:
      assert property ($fell(scl) |-> sclHeldLow) else $error("scl low phase too short");
   AST_TGT_MOVES_SCL_LOW:
      assert property ($changed(tgtSdaOe) |-> !scl) else $error("target sda moved with scl high");
   AST_ONLY_CTRL_FRAMES:
      assert property ($fell(sda) && scl |-> ctrlSdaOe) else $error("start not made by controller");
   AST_ADDR_MATCH_ACK:
      assert property (ack9 && first_r |-> sda == (sh_r[7:1] != {4'h4, addrStrap})) else $error("address ack wrong");
   AST_WRITE_ACKED:
      assert property (ack9 && wr_r |-> !sda) else $error("write byte not acked");
   AST_READ_CTRL_OFF:
      assert property (rise && rd_r && bit_r < 4'h8 |-> !ctrlSdaOe) else $error("controller drove read data");
   AST_READ_ACK_BY_CTRL:
      assert property (ack9 && rd_r |-> !tgtSdaOe) else $error("target drove read ack slot");
   AST_STOP_RELEASES:
      assert property (sto |=> !tgtSdaOe [*8]) else $error("target drove after stop");
endmodule : iox_link_props

//--- tb_top.sv
// self-checking bench: controller and expander joined over the link
`timescale 1ns/1ps
module tb_top;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
   logic [7:0]  wbAdr = 8'h00;
   logic [3:0]  wbSel = 4'h0;
   logic [31:0] wbDat = 32'h0, wbDatO, rng = 32'h84E6;
   logic [2:0]  addrStrap = 3'h0;
   logic [15:0] pinIn = 16'h0, pinOut, pinOe;
   logic [7:0]  regs [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
   int          n_mismatch = 0, n_checks = 0, cyc = 0;
   iox_i2c_if busIf ();
   iox_ctrl #(.QTR_CYC(8)) u_iox_ctrl (.bus(busIf), .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
   iox_target u_iox_target (.bus(busIf), .sys_clk(sys_clk), .resetn(resetn), .addrStrap(addrStrap),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
   iox_link_props u_iox_link_props (.sys_clk(sys_clk), .resetn(resetn), .ctrlSclOe(busIf.ctrlSclOe),
      .ctrlSdaOe(busIf.ctrlSdaOe), .tgtSdaOe(busIf.tgtSdaOe), .scl(busIf.scl), .sda(busIf.sda),
      .addrStrap(addrStrap));
   always #20 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // input registers show synced pins through the invert mask
   function automatic logic [7:0] expR(input int s);
      if (s > 1)
         return regs[s];
      return ((s == 1) ? pinIn[15:8] : pinIn[7:0]) ^ regs[s + 4];
   endfunction : expR
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
      @(posedge sys_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe  <= we;
      wbSel <= 4'hF;
      wbAdr <= adr;
      wbDat <= dat;
      do @(posedge sys_clk); while (wbAck !== 1'b1);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : wb
   task automatic xfer(input logic rdOp, input logic [6:0] ta, input int s, input logic [15:0] wd,
                       input logic tw, output logic [15:0] got, output logic nk);
      logic [31:0] v;
      wb(1'b1, 8'h04, {25'h0, ta}, v);
      wb(1'b1, 8'h08, s, v);
      wb(1'b1, 8'h0C, {16'h0, wd}, v);
      wb(1'b1, 8'h00, {29'h0, tw, rdOp, 1'b1}, v);
      do wb(1'b0, 8'h14, 32'h0, v); while (v[0] !== 1'b0);
      nk = v[1];
      wb(1'b0, 8'h10, 32'h0, v);
      got = v[15:0];
   endtask : xfer
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         n_mismatch++;
         conclude();
      end
   end
   initial
   begin
      logic [15:0] got;
      logic [31:0] v;
      logic [6:0]  ta;
      logic        nk;
      int          s;
      rng = xs(rng);
      addrStrap <= rng[2:0];
      ta = {4'h4, rng[2:0]};
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check(pinOut, 16'hFFFF);
      check(pinOe, 16'h0000);
      wb(1'b0, 8'h18, 32'h0, v);
      check(v[15:0], 16'h0000);
      // first eight passes read reset values, later passes write then read back
      for (int i = 0; i < 20; i++)
      begin
         rng = xs(rng);
         pinIn <= rng[31:16];
         s = i % 8;
         if (i >= 8)
         begin
            // even passes write a single byte
            xfer(1'b0, ta, s, rng[15:0], i[0], got, nk);
            check({15'h0, nk}, 16'h0);
            if (s > 1)
            begin
               regs[s] = rng[7:0];
               if (i[0])
                  regs[s ^ 1] = rng[15:8];
            end
            check(pinOut, {regs[3], regs[2]});
            check(pinOe, ~{regs[7], regs[6]});
            s = s ^ 1;
         end
         xfer(1'b1, ta, s, 16'h0, 1'b1, got, nk);
         check(got, {expR(s ^ 1), expR(s)});
      end
      // mid-run reset brings every register back to its default
      resetn <= 1'b0;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      regs = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
      @(posedge sys_clk);
      check(pinOut, 16'hFFFF);
      check(pinOe, 16'h0000);
      xfer(1'b1, ta, 2, 16'h0, 1'b1, got, nk);
      check(got, {expR(3), expR(2)});
      // foreign addresses stay silent
      for (int k = 1; k < 8; k += 3)
      begin
         xfer(1'b0, ta ^ 7'(k), 6, 16'h0, 1'b1, got, nk);
         check({15'h0, nk}, 16'h1);
         check(pinOe, ~{regs[7], regs[6]});
      end
      conclude();
   end
endmodule : tb_top
